// >>> common/qdc_consts.vh
`ifndef QDC_CONSTS_VH
`define QDC_CONSTS_VH

// serial frame layout
`define QDC_FRAME_BITS        24
`define QDC_CNT_W             5
`define QDC_FRM_RW_BIT        23
`define QDC_FRM_ADDR_HI       22
`define QDC_FRM_ADDR_LO       21
`define QDC_FRM_SEL_HI        20
`define QDC_FRM_SEL_LO        16
`define QDC_FRM_REG_HI        20
`define QDC_FRM_REG_LO        18
`define QDC_FRM_CHAN_HI       17
`define QDC_FRM_CHAN_LO       16
`define QDC_FRM_DATA_HI       15
`define QDC_FRM_DATA_LO       0

// register group code carried in the frame for control-type writes
`define QDC_REG_CONTROL       3'h7

// top three data bits pick the control register
`define QDC_KEY_HI            15
`define QDC_KEY_LO            13
`define QDC_KEY_BOOST         3'h3
`define QDC_KEY_SLEW          3'h0

// boost converter control fields
`define QDC_BST_COMP_BIT      6
`define QDC_BST_PHASE_HI      5
`define QDC_BST_PHASE_LO      4
`define QDC_BST_FREQ_HI       3
`define QDC_BST_FREQ_LO       2
`define QDC_BST_MAXV_HI       1
`define QDC_BST_MAXV_LO       0
`define QDC_BST_COMP_RST      1'b0
`define QDC_BST_PHASE_RST     2'h0
`define QDC_BST_FREQ_RST      2'h1
`define QDC_BST_MAXV_RST      2'h0

// slew limit control fields
`define QDC_SLW_EN_BIT        12
`define QDC_SLW_RATE_HI       6
`define QDC_SLW_RATE_LO       3
`define QDC_SLW_STEP_HI       2
`define QDC_SLW_STEP_LO       0
`define QDC_SLW_EN_RST        1'b0
`define QDC_SLW_RATE_RST      4'h0
`define QDC_SLW_STEP_RST      3'h0

// readback selector codes
`define QDC_SEL_DATA_BASE     5'h00
`define QDC_SEL_CTRL_BASE     5'h04
`define QDC_SEL_GAIN_BASE     5'h08
`define QDC_SEL_OFFS_BASE     5'h0c
`define QDC_SEL_CLR_BASE      5'h10
`define QDC_SEL_SLEW_BASE     5'h14
`define QDC_SEL_STATUS        5'h18
`define QDC_SEL_MAIN_CTRL     5'h19
`define QDC_SEL_BOOST         5'h1a

// no-operation frame for device address 00
`define QDC_NOP_FRAME         24'h1ce000

`endif

// >>> design/qdc_config_readback.v
`timescale 1ns/10ps
`include "qdc_consts.vh"
module qdc_config_readback (
  input  wire        CLK,
  input  wire        ARST_N,
  input  wire        SCLK,
  input  wire        SYNC_N,
  input  wire        SDIN,
  input  wire [1:0]  DEV_ADDR,
  input  wire        STATUS_ON_EVERY_WRITE,
  input  wire [63:0] DAC_DATA_IMG,
  input  wire [63:0] DAC_CTRL_IMG,
  input  wire [63:0] DAC_GAIN_IMG,
  input  wire [63:0] DAC_OFFS_IMG,
  input  wire [63:0] DAC_CLR_IMG,
  input  wire [15:0] STATUS_IMG,
  input  wire [15:0] MAIN_CTRL_IMG,
  output reg         SERIAL_DATA_OUT,
  output reg         SERIAL_DATA_OUT_OE,
  output reg         CONVERTER_COMPENSATION_SELECT,
  output reg  [1:0]  CONVERTER_PHASE_SELECT,
  output reg  [1:0]  CONVERTER_SWITCH_RATE_SELECT,
  output reg  [1:0]  BOOST_CEILING_SELECT,
  output reg  [3:0]  SLEW_LIMIT_ON,
  output reg  [15:0] SLEW_UPDATE_RATE,
  output reg  [11:0] SLEW_INCREMENT_SIZE
);

  // frame width kept as a parameter so a longer word could be tried
  parameter FRAME_BITS = `QDC_FRAME_BITS;

  // synchronised pin levels
  wire       sclk_s;
  wire       sync_n_s;
  wire       sdin_s;
  wire [1:0] addr_s;

  reg                    sclk_d_reg;
  reg                    sync_n_d_reg;
  reg [FRAME_BITS-1:0]   rx_reg;
  reg [FRAME_BITS-1:0]   tx_reg;
  reg [`QDC_CNT_W-1:0]   bit_cnt_reg;
  reg                    pend_reg;
  reg [4:0]              pend_sel_reg;

  wire sclk_fall  = sclk_d_reg & ~sclk_s;
  wire frame_open = sync_n_d_reg & ~sync_n_s;
  wire frame_shut = ~sync_n_d_reg & sync_n_s;
  // falling serial edge inside an open frame
  wire shift_edge = ~sync_n_s & sclk_fall;

  // every serial and address pin crosses two flops before anything looks at it; serial clock and
  // frame strobe reset high, their idle level, so reset makes no false edge
  qdc_sync #(
    .WIDTH   (5),
    .RST_VAL (5'h18)
  ) u_pin_sync (
    .clk    (CLK),
    .arst_n (ARST_N),
    .din    ({SCLK, SYNC_N, SDIN, DEV_ADDR}),
    .dout   ({sclk_s, sync_n_s, sdin_s, addr_s})
  );

  // 16-bit readback image of a channel's slew settings
  function [15:0] slew_word;
    input       en;
    input [3:0] rate;
    input [2:0] step;
    begin
      slew_word = {`QDC_KEY_SLEW, en, 5'h00, rate, step};
    end
  endfunction

  // one 16-bit lane out of a four-channel image
  function [15:0] lane;
    input [63:0] img;
    input [1:0]  ch;
    begin
      lane = img[16*ch +: 16];
    end
  endfunction

  // 16-bit readback image of the boost converter settings
  function [15:0] boost_word;
    input       comp;
    input [1:0] phase;
    input [1:0] rate;
    input [1:0] ceil;
    begin
      boost_word = {`QDC_KEY_BOOST, 6'h00, comp, phase, rate, ceil};
    end
  endfunction

  // selectors past the per-channel groups; codes 27 and up read as zero
  function [15:0] misc_word;
    input [4:0] sel;
    begin
      case (sel)
        `QDC_SEL_STATUS:    misc_word = STATUS_IMG;
        `QDC_SEL_MAIN_CTRL: misc_word = MAIN_CTRL_IMG;
        `QDC_SEL_BOOST:     misc_word = boost_word(CONVERTER_COMPENSATION_SELECT, CONVERTER_PHASE_SELECT,
                                                   CONVERTER_SWITCH_RATE_SELECT, BOOST_CEILING_SELECT);
        default:            misc_word = 16'h0000;
      endcase
    end
  endfunction

  // readback source selection by selector code
  function [15:0] read_mux;
    input [4:0] sel;
    reg   [1:0] ch;
    begin
      ch = sel[1:0];
      case (sel[4:2])
        3'h0: read_mux = lane(DAC_DATA_IMG, ch);
        3'h1: read_mux = lane(DAC_CTRL_IMG, ch);
        3'h2: read_mux = lane(DAC_GAIN_IMG, ch);
        3'h3: read_mux = lane(DAC_OFFS_IMG, ch);
        3'h4: read_mux = lane(DAC_CLR_IMG, ch);
        3'h5: read_mux = slew_word(SLEW_LIMIT_ON[ch], SLEW_UPDATE_RATE[4*ch +: 4],
                                   SLEW_INCREMENT_SIZE[3*ch +: 3]);
        3'h6: read_mux = misc_word(sel);
        default: read_mux = 16'h0000;
      endcase
    end
  endfunction

  // bit count of a complete frame, held at the counter's own width
  localparam [`QDC_CNT_W-1:0] FULL_CNT = FRAME_BITS;

  // decoded view of the word just closed
  wire       frm_full  = (bit_cnt_reg == FULL_CNT);
  wire       frm_mine  = (rx_reg[`QDC_FRM_ADDR_HI:`QDC_FRM_ADDR_LO] == addr_s);
  wire       frm_read  = rx_reg[`QDC_FRM_RW_BIT];
  wire       frm_ctrl  = (rx_reg[`QDC_FRM_REG_HI:`QDC_FRM_REG_LO] == `QDC_REG_CONTROL);
  // the no-op carries key 111, which matches no register, so it writes nothing
  wire [2:0] frm_key   = rx_reg[`QDC_KEY_HI:`QDC_KEY_LO];
  wire [1:0] frm_chan  = rx_reg[`QDC_FRM_CHAN_HI:`QDC_FRM_CHAN_LO];
  // only a whole frame for this device is acted on; a cut or foreign frame
  // leaves every register and any pending read as they were
  wire       accept    = frame_shut & frm_full & frm_mine;
  wire       wr_boost  = accept & ~frm_read & frm_ctrl & (frm_key == `QDC_KEY_BOOST);
  wire       wr_slew   = accept & ~frm_read & frm_ctrl & (frm_key == `QDC_KEY_SLEW);

  // edge history of the synchronised clock and frame strobe
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sclk_d_reg   <= 1'b1;
      sync_n_d_reg <= 1'b1;
    end else begin
      sclk_d_reg   <= sclk_s;
      sync_n_d_reg <= sync_n_s;
    end
  end

  // receive side: sample the input and count falling edges of the frame
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_reg      <= {FRAME_BITS{1'b0}};
      bit_cnt_reg <= {`QDC_CNT_W{1'b0}};
    end else if (frame_open) begin
      rx_reg      <= {FRAME_BITS{1'b0}};
      bit_cnt_reg <= {`QDC_CNT_W{1'b0}};
    end else if (shift_edge) begin
      rx_reg <= {rx_reg[FRAME_BITS-2:0], sdin_s};
      // saturate so an overlong frame is seen as malformed, not wrapped
      if (bit_cnt_reg != {`QDC_CNT_W{1'b1}})
        bit_cnt_reg <= bit_cnt_reg + 1'b1;
    end
  end

  // transmit side: the outgoing word is fixed as the frame opens and moves on
  // at each falling serial edge; the host samples it a full period later, just before the next fall
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_reg <= {FRAME_BITS{1'b0}};
    end else if (frame_open) begin
      if (pend_reg)
        tx_reg <= {3'h0, pend_sel_reg, read_mux(pend_sel_reg)};
      else if (STATUS_ON_EVERY_WRITE)
        tx_reg <= {8'h00, STATUS_IMG};
      else
        tx_reg <= {FRAME_BITS{1'b0}};
    end else if (shift_edge) begin
      tx_reg <= {tx_reg[FRAME_BITS-2:0], 1'b0};
    end
  end

  // serial output drives only while the frame strobe is low; the opening
  // cycle stays low so a bit left over from a cut frame never leaks out
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SERIAL_DATA_OUT    <= 1'b0;
      SERIAL_DATA_OUT_OE <= 1'b0;
    end else begin
      SERIAL_DATA_OUT    <= ~sync_n_s & ~frame_open & tx_reg[FRAME_BITS-1];
      SERIAL_DATA_OUT_OE <= ~sync_n_s;
    end
  end

  reg       pend_next;
  reg [4:0] pend_sel_next;

  // read request bookkeeping: a request arms the next frame's output,
  // any other accepted frame (write or no-op) consumes it
  always @* begin
    pend_next     = pend_reg;
    pend_sel_next = pend_sel_reg;
    if (accept) begin
      pend_next = frm_read;
      if (frm_read)
        pend_sel_next = rx_reg[`QDC_FRM_SEL_HI:`QDC_FRM_SEL_LO];
    end
  end

  // pending read state
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pend_reg     <= 1'b0;
      pend_sel_reg <= 5'h00;
    end else begin
      pend_reg     <= pend_next;
      pend_sel_reg <= pend_sel_next;
    end
  end

  reg       comp_next;
  reg [1:0] phase_next;
  reg [1:0] rate_next;
  reg [1:0] ceil_next;

  // next boost fields: hold unless an accepted boost write lands;
  // bits 12..7 of the data are never looked at
  always @* begin
    comp_next  = CONVERTER_COMPENSATION_SELECT;
    phase_next = CONVERTER_PHASE_SELECT;
    rate_next  = CONVERTER_SWITCH_RATE_SELECT;
    ceil_next  = BOOST_CEILING_SELECT;
    if (wr_boost) begin
      comp_next  = rx_reg[`QDC_BST_COMP_BIT];
      phase_next = rx_reg[`QDC_BST_PHASE_HI:`QDC_BST_PHASE_LO];
      rate_next  = rx_reg[`QDC_BST_FREQ_HI:`QDC_BST_FREQ_LO];
      ceil_next  = rx_reg[`QDC_BST_MAXV_HI:`QDC_BST_MAXV_LO];
    end
  end

  // boost converter control register
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CONVERTER_COMPENSATION_SELECT <= `QDC_BST_COMP_RST;
      CONVERTER_PHASE_SELECT        <= `QDC_BST_PHASE_RST;
      CONVERTER_SWITCH_RATE_SELECT  <= `QDC_BST_FREQ_RST;
      BOOST_CEILING_SELECT          <= `QDC_BST_MAXV_RST;
    end else begin
      CONVERTER_COMPENSATION_SELECT <= comp_next;
      CONVERTER_PHASE_SELECT        <= phase_next;
      CONVERTER_SWITCH_RATE_SELECT  <= rate_next;
      BOOST_CEILING_SELECT          <= ceil_next;
    end
  end

  reg [3:0]  slew_on_next;
  reg [15:0] slew_rate_next;
  reg [11:0] slew_step_next;

  // next slew fields: only the addressed channel's slice is replaced
  always @* begin
    slew_on_next   = SLEW_LIMIT_ON;
    slew_rate_next = SLEW_UPDATE_RATE;
    slew_step_next = SLEW_INCREMENT_SIZE;
    if (wr_slew) begin
      slew_on_next[frm_chan]          = rx_reg[`QDC_SLW_EN_BIT];
      slew_rate_next[4*frm_chan +: 4] = rx_reg[`QDC_SLW_RATE_HI:`QDC_SLW_RATE_LO];
      slew_step_next[3*frm_chan +: 3] = rx_reg[`QDC_SLW_STEP_HI:`QDC_SLW_STEP_LO];
    end
  end

  // per-channel slew settings register
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SLEW_LIMIT_ON       <= {4{`QDC_SLW_EN_RST}};
      SLEW_UPDATE_RATE    <= {4{`QDC_SLW_RATE_RST}};
      SLEW_INCREMENT_SIZE <= {4{`QDC_SLW_STEP_RST}};
    end else begin
      SLEW_LIMIT_ON       <= slew_on_next;
      SLEW_UPDATE_RATE    <= slew_rate_next;
      SLEW_INCREMENT_SIZE <= slew_step_next;
    end
  end

endmodule // qdc_config_readback

// >>> design/qdc_sync.v
`timescale 1ns/10ps
// two-stage synchroniser for pin-level inputs
module qdc_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input  wire             clk,
  input  wire             arst_n,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage; both stages reset to the
  // idle level of the pins so no false edge is seen as reset lifts
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= RST_VAL;
      dout     <= RST_VAL;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule // qdc_sync

// >>> tb/qdc_assertions.sv
`timescale 1ns/10ps
module qdc_assertions (
  input wire        CLK,
  input wire        ARST_N,
  input wire        SYNC_N,
  input wire        SERIAL_DATA_OUT,
  input wire        SERIAL_DATA_OUT_OE,
  input wire        CONVERTER_COMPENSATION_SELECT,
  input wire [1:0]  CONVERTER_PHASE_SELECT,
  input wire [1:0]  CONVERTER_SWITCH_RATE_SELECT,
  input wire [1:0]  BOOST_CEILING_SELECT,
  input wire [3:0]  SLEW_LIMIT_ON,
  input wire [15:0] SLEW_UPDATE_RATE,
  input wire [11:0] SLEW_INCREMENT_SIZE
);
  // grouped config, so one slip anywhere shows up
  wire [6:0]  bst = {CONVERTER_COMPENSATION_SELECT, CONVERTER_PHASE_SELECT, CONVERTER_SWITCH_RATE_SELECT,
                     BOOST_CEILING_SELECT};
  wire [31:0] slw = {SLEW_LIMIT_ON, SLEW_UPDATE_RATE, SLEW_INCREMENT_SIZE};
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // config moves only once a frame has closed
  a_boost_after_frame: assert property (!$stable(bst) |-> SYNC_N && $past(SYNC_N, 2))
    else $error("boost fields changed inside a frame");
  a_slew_after_frame: assert property (!$stable(slw) |-> SYNC_N && $past(SYNC_N, 2))
    else $error("slew fields changed inside a frame");
  a_no_move_in_frame: assert property (!SYNC_N ##1 !SYNC_N |-> $stable(bst) && $stable(slw))
    else $error("config moved while frame open");
  a_one_channel: assert property ($countones(SLEW_LIMIT_ON ^ $past(SLEW_LIMIT_ON)) <= 1)
    else $error("several slew enables moved at once");
  a_reset_defaults: assert property ($rose(ARST_N) |-> bst == 7'h04 && slw == 32'h0)
    else $error("config not at defaults after reset");
  // output driver follows the frame strobe
  a_idle_no_drive: assert property (SYNC_N [*6] |-> !SERIAL_DATA_OUT_OE)
    else $error("serial output driven between frames");
  a_frame_drives: assert property (!SYNC_N [*6] |-> SERIAL_DATA_OUT_OE)
    else $error("serial output not driven in frame");
  a_quiet_when_idle: assert property (!SERIAL_DATA_OUT_OE |-> !SERIAL_DATA_OUT)
    else $error("serial data high while not driving");
endmodule // qdc_assertions
bind qdc_config_readback qdc_assertions u_chk (
  .CLK                           (CLK),
  .ARST_N                        (ARST_N),
  .SYNC_N                        (SYNC_N),
  .SERIAL_DATA_OUT               (SERIAL_DATA_OUT),
  .SERIAL_DATA_OUT_OE            (SERIAL_DATA_OUT_OE),
  .CONVERTER_COMPENSATION_SELECT (CONVERTER_COMPENSATION_SELECT),
  .CONVERTER_PHASE_SELECT        (CONVERTER_PHASE_SELECT),
  .CONVERTER_SWITCH_RATE_SELECT  (CONVERTER_SWITCH_RATE_SELECT),
  .BOOST_CEILING_SELECT          (BOOST_CEILING_SELECT),
  .SLEW_LIMIT_ON                 (SLEW_LIMIT_ON),
  .SLEW_UPDATE_RATE              (SLEW_UPDATE_RATE),
  .SLEW_INCREMENT_SIZE           (SLEW_INCREMENT_SIZE)
);

// >>> tb/qdc_host.sv
`timescale 1ns/10ps
module qdc_host (
  input  wire  clk,
  output logic sclk,
  output logic sync_n,
  output logic sdin,
  input  wire  serial_data_out
);
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdin = 1'b0;
  end
  // one 24-bit frame; clock stands high outside frames, data set while high
  task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
    @(posedge clk);
    sync_n <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 23; i >= 0; i--) begin
      sdin <= tx[i];
      repeat (4) @(posedge clk);
      rx[i] = serial_data_out;
      sclk <= 1'b0;
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
    end
    repeat (4) @(posedge clk);
    sync_n <= 1'b1;
    sdin <= ~sdin; // released line must not keep the last bit
    repeat (8) @(posedge clk);
  endtask
endmodule // qdc_host

// >>> tb/test_qdc_config_readback.sv
`timescale 1ns/10ps
`include "qdc_consts.vh"
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module test_qdc_config_readback;
  logic        clk, arst_n, sow;
  logic [1:0]  da = 2'h2;
  logic [63:0] img [0:4];
  logic [15:0] sts = 16'h8a51, mcr = 16'h2c07, bw, sw [0:3];
  logic [23:0] rx, nop;
  wire         sclk, sync_n, sdin, serial_data_out, comp, oe;
  wire  [1:0]  ph, rt, cl;
  wire  [3:0]  en;
  wire  [15:0] sr;
  wire  [11:0] ss;
  int          failures = 0, check_count = 0;
  qdc_config_readback u_dut (.CLK(clk), .ARST_N(arst_n), .SCLK(sclk), .SYNC_N(sync_n), .SDIN(sdin),
    .DEV_ADDR(da), .STATUS_ON_EVERY_WRITE(sow), .DAC_DATA_IMG(img[0]), .DAC_CTRL_IMG(img[1]),
    .DAC_GAIN_IMG(img[2]), .DAC_OFFS_IMG(img[3]), .DAC_CLR_IMG(img[4]), .STATUS_IMG(sts),
    .MAIN_CTRL_IMG(mcr), .SERIAL_DATA_OUT(serial_data_out), .SERIAL_DATA_OUT_OE(oe), .CONVERTER_COMPENSATION_SELECT(comp),
    .CONVERTER_PHASE_SELECT(ph), .CONVERTER_SWITCH_RATE_SELECT(rt), .BOOST_CEILING_SELECT(cl),
    .SLEW_LIMIT_ON(en), .SLEW_UPDATE_RATE(sr), .SLEW_INCREMENT_SIZE(ss));
  qdc_host u_host (.clk(clk), .sclk(sclk), .sync_n(sync_n), .sdin(sdin), .serial_data_out(serial_data_out));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic wr(input logic [1:0] a, input logic [1:0] ch, input logic [15:0] d);
    u_host.xfer({1'b0, a, 3'b111, ch, d}, rx);
  endtask
  // expected readback word for a selector
  function automatic logic [15:0] ex(input int s);
    if (s < 20) return img[s / 4][16 * (s % 4) +: 16];
    if (s < 24) return sw[s - 20];
    return (s == 24) ? sts : (s == 25) ? mcr : bw;
  endfunction
  task automatic chk_cfg(input string n);
    logic [3:0]  e_en;
    logic [15:0] e_sr;
    logic [11:0] e_ss;
    for (int c = 0; c < 4; c++) begin
      e_en[c] = sw[c][12];
      e_sr[4*c +: 4] = sw[c][6:3];
      e_ss[3*c +: 3] = sw[c][2:0];
    end
    `CHK(n, bw[6:0], {comp, ph, rt, cl})
    `CHK(n, {e_en, e_sr, e_ss}, {en, sr, ss})
    `CHK(n, 1'b0, oe)
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    report_and_stop;
  end
  initial begin
    arst_n = 1'b0;
    sow = 1'b0;
    bw = 16'h6004;
    nop = `QDC_NOP_FRAME | {1'b0, da, 21'h0};
    for (int g = 0; g < 20; g++) img[g / 4][16 * (g % 4) +: 16] = 16'h1000 * g + 16'h3c;
    for (int c = 0; c < 4; c++) sw[c] = 16'h0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk_cfg("reset");
    $display("test reset done");
    for (int v = 0; v < 4; v++) begin
      bw[6:0] = {v[0], v[1:0], (v == 3) ? 2'h0 : v[1:0], ~v[1:0]};
      wr(da, 2'h0, {3'b011, 6'h3f, bw[6:0]});
      chk_cfg("boost");
      sw[v] = {4'h1, 5'h0, 4'(v * 5 + 3), 3'(v + 1)};
      wr(da, v[1:0], {sw[v][15:12], 5'h1f, sw[v][6:0]});
      chk_cfg("slew");
    end
    wr(da ^ 2'h1, 2'h0, 16'h607f);
    chk_cfg("other address");
    sow <= 1'b1;
    wr(da, 2'h1, 16'h907f);
    `CHK("status on write", {8'h00, sts}, rx)
    chk_cfg("wrong key");
    sow <= 1'b0;
    u_host.xfer(nop, rx);
    `CHK("quiet frame", 24'h0, rx)
    chk_cfg("no-op");
    $display("test writes done");
    // each read frame also collects the previous request's word
    for (int s = 0; s <= 27; s++) begin
      u_host.xfer((s < 27) ? {1'b1, da, 5'(s), 16'hffff} : nop, rx);
      if (s > 0) `CHK("readback", {3'b000, 5'(s - 1), ex(s - 1)}, rx)
    end
    u_host.xfer({1'b1, da, 5'h19, 16'h0}, rx);
    u_host.xfer({1'b1, da ^ 2'h1, 5'h00, 16'h0}, rx);
    u_host.xfer(nop, rx);
    `CHK("pending read kept", {8'h19, mcr}, rx)
    $display("test readback done");
    report_and_stop;
  end
endmodule // test_qdc_config_readback
